// File: mpk_map.vh
/*
  Timing counts and pin-level constants for the module power-key host controller.
  Assumes a 20 MHz system clock; counts are expressed in milliseconds and scaled by ticks per millisecond.
*/
`ifndef MPK_MAP_VH
`define MPK_MAP_VH
`define MPK_CLK_HZ          20000000
`define MPK_TICKS_PER_MS    16'h4e20
`define MPK_ON_PRESS_MS     16'h1388
`define MPK_OFF_PRESS_MS    16'h0bb8
`define MPK_WAKE_PRESS_MS   16'h1388
`define MPK_EOFF_PRESS_MS   16'h00c8
`define MPK_OFF_WAIT_MS     16'h03e8
`define MPK_OFF_TIMEOUT_MS  16'h3a98
`define MPK_ON_TIMEOUT_MS   16'h2710
`define MPK_MS_W            16
`define MPK_TICK_W          16
`define MPK_ST_W            4
`define MPK_ERR_NONE        2'h0
`define MPK_ERR_ON_FAIL     2'h1
`define MPK_ERR_OFF_FAIL    2'h2
`define MPK_ERR_REFUSED     2'h3
`endif

// File: mpk_ms_tick.v
/*
  Millisecond enable divider for the power-key host controller.
  Assumes one system clock; emits a one-cycle pulse every ticks_per_ms cycles.
*/
`include "mpk_map.vh"
module mpk_ms_tick #(
  parameter [`MPK_TICK_W-1:0] TICKS_PER_MS = `MPK_TICKS_PER_MS
) (
  input  wire clk_sys_in,
  input  wire rst_b_in,
  output reg  ms_tick_out
);
  reg [`MPK_TICK_W-1:0] count;
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count       <= {`MPK_TICK_W{1'b0}};
      ms_tick_out <= 1'b0;
    end else if (count == TICKS_PER_MS - 1'b1) begin
      count       <= {`MPK_TICK_W{1'b0}};
      ms_tick_out <= 1'b1;
    end else begin
      count       <= count + 1'b1;
      ms_tick_out <= 1'b0;
    end
  end
endmodule

// File: mpk_host_ctrl.v
/*
  Host-side power sequencer for a cellular module: power key and emergency-off open-drain drivers,
  powered-indicator monitoring, fast power-down request pin, and usb supply sense control.
  Assumes all inputs synchronous to clk_sys_in and external open-drain stages resolving the pins.
*/
`include "mpk_map.vh"
module mpk_host_ctrl #(
  parameter [`MPK_TICK_W-1:0] TICKS_PER_MS   = `MPK_TICKS_PER_MS,
  parameter [`MPK_MS_W-1:0]   ON_PRESS_MS    = `MPK_ON_PRESS_MS,
  parameter [`MPK_MS_W-1:0]   OFF_PRESS_MS   = `MPK_OFF_PRESS_MS,
  parameter [`MPK_MS_W-1:0]   WAKE_PRESS_MS  = `MPK_WAKE_PRESS_MS,
  parameter [`MPK_MS_W-1:0]   EOFF_PRESS_MS  = `MPK_EOFF_PRESS_MS,
  parameter [`MPK_MS_W-1:0]   OFF_WAIT_MS    = `MPK_OFF_WAIT_MS,
  parameter [`MPK_MS_W-1:0]   OFF_TIMEOUT_MS = `MPK_OFF_TIMEOUT_MS,
  parameter [`MPK_MS_W-1:0]   ON_TIMEOUT_MS  = `MPK_ON_TIMEOUT_MS
) (
  input  wire       clk_sys_in,
  input  wire       rst_b_in,
  input  wire       power_on_req_in,
  input  wire       power_off_req_in,
  input  wire       wake_req_in,
  input  wire       emergency_req_in,
  input  wire       quick_off_req_in,
  input  wire       main_supply_ok_in,
  input  wire       powered_indicator_in,
  input  wire       psm_active_in,
  input  wire       usb_present_in,
  output reg        power_key_out,
  output reg        power_key_oe_b_out,
  output reg        emergency_off_n_out,
  output reg        emergency_off_n_oe_b_out,
  output reg        quick_off_pin_out,
  output reg        usb_supply_sense_en_out,
  output reg        busy_out,
  output reg        module_on_out,
  output reg        deep_sleep_out,
  output reg        done_out,
  output reg [1:0]  error_out
);
  localparam [`MPK_ST_W-1:0] ST_IDLE     = 4'h0;
  localparam [`MPK_ST_W-1:0] ST_ON_PRESS = 4'h1;
  localparam [`MPK_ST_W-1:0] ST_ON_WAIT  = 4'h2;
  localparam [`MPK_ST_W-1:0] ST_OFF_PRS  = 4'h3;
  localparam [`MPK_ST_W-1:0] ST_OFF_WAIT = 4'h4;
  localparam [`MPK_ST_W-1:0] ST_EOFF     = 4'h5;
  localparam [`MPK_ST_W-1:0] ST_EOFF_REL = 4'h6;
  localparam [`MPK_ST_W-1:0] ST_WAKE     = 4'h7;
  localparam [`MPK_ST_W-1:0] ST_QOFF     = 4'h8;

  wire                  ms_tick;
  reg [`MPK_ST_W-1:0]   state;
  reg [`MPK_ST_W-1:0]   next_state;
  reg [`MPK_MS_W-1:0]   ms_count;
  reg                   next_clear;
  reg                   retried;
  reg                   next_retried;
  reg                   next_done;
  reg [1:0]             next_error;
  reg                   key_low;
  reg                   eoff_low;
  reg                   qoff_low;

  // time reached when the elapsed millisecond count meets the limit
  function elapsed;
    input [`MPK_MS_W-1:0] count;
    input [`MPK_MS_W-1:0] limit;
    begin
      elapsed = (count >= limit);
    end
  endfunction

  mpk_ms_tick #(
    .TICKS_PER_MS (TICKS_PER_MS)
  ) u_tick (
    .clk_sys_in  (clk_sys_in),
    .rst_b_in    (rst_b_in),
    .ms_tick_out (ms_tick)
  );

  always @* begin
    next_state   = state;
    next_clear   = 1'b0;
    next_retried = retried;
    next_done    = 1'b0;
    next_error   = `MPK_ERR_NONE;
    case (state)
      ST_IDLE: begin
        next_clear = 1'b1;
        if (emergency_req_in) begin
          if (powered_indicator_in && !psm_active_in) begin
            next_state = ST_EOFF;
          end else begin
            next_done  = 1'b1;
            next_error = `MPK_ERR_REFUSED;
          end
        end else if (quick_off_req_in && powered_indicator_in) begin
          next_state = ST_QOFF;
        end else if (power_off_req_in && powered_indicator_in) begin
          next_state = ST_OFF_PRS;
        end else if (wake_req_in && psm_active_in && !powered_indicator_in) begin
          next_state = ST_WAKE;
        end else if (power_on_req_in && !powered_indicator_in && main_supply_ok_in) begin
          next_retried = 1'b0;
          next_state   = ST_ON_PRESS;
        end
      end
      ST_ON_PRESS: begin
        if (elapsed(ms_count, ON_PRESS_MS)) begin
          next_clear = 1'b1;
          next_state = ST_ON_WAIT;
        end
      end
      ST_ON_WAIT: begin
        if (powered_indicator_in) begin
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end else if (elapsed(ms_count, ON_TIMEOUT_MS)) begin
          next_clear = 1'b1;
          if (!retried) begin
            next_retried = 1'b1;
            next_state   = ST_EOFF;
          end else begin
            next_done  = 1'b1;
            next_error = `MPK_ERR_ON_FAIL;
            next_state = ST_IDLE;
          end
        end
      end
      ST_OFF_PRS: begin
        if (elapsed(ms_count, OFF_PRESS_MS)) begin
          next_clear = 1'b1;
          next_state = ST_OFF_WAIT;
        end
      end
      ST_OFF_WAIT: begin
        // the module detaches and closes its files first, so low is not trusted before the wait
        if (!powered_indicator_in && elapsed(ms_count, OFF_WAIT_MS)) begin
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end else if (elapsed(ms_count, OFF_TIMEOUT_MS)) begin
          next_done  = 1'b1;
          next_error = `MPK_ERR_OFF_FAIL;
          next_state = ST_IDLE;
        end
      end
      ST_EOFF: begin
        if (elapsed(ms_count, EOFF_PRESS_MS)) begin
          next_clear = 1'b1;
          next_state = ST_EOFF_REL;
        end
      end
      ST_EOFF_REL: begin
        if (!powered_indicator_in) begin
          next_clear = 1'b1;
          if (retried) begin
            next_state = ST_ON_PRESS;
          end else begin
            next_done  = 1'b1;
            next_state = ST_IDLE;
          end
        end else if (elapsed(ms_count, OFF_TIMEOUT_MS)) begin
          next_done  = 1'b1;
          next_error = `MPK_ERR_OFF_FAIL;
          next_state = ST_IDLE;
        end
      end
      ST_WAKE: begin
        if (elapsed(ms_count, WAKE_PRESS_MS)) begin
          next_clear = 1'b1;
          next_state = ST_ON_WAIT;
        end
      end
      ST_QOFF: begin
        if (!powered_indicator_in) begin
          next_done  = 1'b1;
          next_state = ST_IDLE;
        end else if (elapsed(ms_count, OFF_TIMEOUT_MS)) begin
          next_done  = 1'b1;
          next_error = `MPK_ERR_OFF_FAIL;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    key_low  = (next_state == ST_ON_PRESS) || (next_state == ST_OFF_PRS) || (next_state == ST_WAKE);
    eoff_low = (next_state == ST_EOFF);
    qoff_low = (next_state == ST_QOFF);
  end

  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state                    <= ST_IDLE;
      ms_count                 <= {`MPK_MS_W{1'b0}};
      retried                  <= 1'b0;
      power_key_out            <= 1'b0;
      power_key_oe_b_out       <= 1'b1;
      emergency_off_n_out      <= 1'b0;
      emergency_off_n_oe_b_out <= 1'b1;
      quick_off_pin_out        <= 1'b0;
      usb_supply_sense_en_out  <= 1'b0;
      busy_out                 <= 1'b0;
      module_on_out            <= 1'b0;
      deep_sleep_out           <= 1'b0;
      done_out                 <= 1'b0;
      error_out                <= `MPK_ERR_NONE;
    end else begin
      state   <= next_state;
      retried <= next_retried;
      if (next_clear) begin
        ms_count <= {`MPK_MS_W{1'b0}};
      end else if (ms_tick && ms_count != {`MPK_MS_W{1'b1}}) begin
        ms_count <= ms_count + 1'b1;
      end
      power_key_out            <= 1'b0;
      power_key_oe_b_out       <= ~key_low;
      emergency_off_n_out      <= 1'b0;
      emergency_off_n_oe_b_out <= ~eoff_low;
      // quick-off pin idles high while on, falls to request and during the off wait, stays low while off
      quick_off_pin_out        <= powered_indicator_in && !qoff_low && next_state != ST_OFF_WAIT;
      usb_supply_sense_en_out  <= usb_present_in && powered_indicator_in && !psm_active_in;
      busy_out                 <= (next_state != ST_IDLE);
      module_on_out            <= powered_indicator_in;
      deep_sleep_out           <= psm_active_in && !powered_indicator_in;
      done_out                 <= next_done;
      error_out                <= next_done ? next_error : error_out;
    end
  end
endmodule

// File: mpk_host_sva.sv
/*
  Concurrent checks on the power-key host controller ports.
  Assumes the bench shortens presses so the shortest press lasts at least 8 clocks.
*/
module mpk_host_sva (
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  input wire logic       power_on_req_in,
  input wire logic       power_off_req_in,
  input wire logic       wake_req_in,
  input wire logic       emergency_req_in,
  input wire logic       quick_off_req_in,
  input wire logic       main_supply_ok_in,
  input wire logic       powered_indicator_in,
  input wire logic       psm_active_in,
  input wire logic       power_key_out,
  input wire logic       power_key_oe_b_out,
  input wire logic       emergency_off_n_out,
  input wire logic       emergency_off_n_oe_b_out,
  input wire logic       quick_off_pin_out,
  input wire logic       usb_supply_sense_en_out,
  input wire logic       busy_out,
  input wire logic       done_out,
  input wire logic [1:0] error_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  wire only_on = power_on_req_in && !busy_out && !emergency_req_in && !quick_off_req_in
                 && !power_off_req_in && !wake_req_in && !powered_indicator_in;
  AST_KEY_NEVER_HIGH: assert property (power_key_out == 1'b0) else $error("key driven high");
  AST_EOFF_NEVER_HIGH: assert property (emergency_off_n_out == 1'b0) else $error("eoff driven high");
  AST_ON_START: assert property (only_on && main_supply_ok_in |=> !power_key_oe_b_out && busy_out)
    else $error("power-on press not started");
  AST_ON_LOW_SUPPLY: assert property (only_on && !main_supply_ok_in |=> power_key_oe_b_out && !busy_out)
    else $error("press made on low supply");
  AST_PRESS_MIN: assert property ($fell(power_key_oe_b_out) |-> !power_key_oe_b_out [*8])
    else $error("key press too short");
  AST_EOFF_REFUSE: assert property (!busy_out && emergency_req_in && (psm_active_in || !powered_indicator_in)
    |=> (done_out && emergency_off_n_oe_b_out) ##1 (error_out == 2'h3)) else $error("emergency not refused");
  AST_DONE_PULSE: assert property (done_out |=> !done_out) else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(busy_out) |-> done_out) else $error("busy ended without done");
  AST_USB_PSM: assert property (psm_active_in |=> !usb_supply_sense_en_out) else $error("usb sense on in psm");
  AST_QUICK_FALL: assert property (!busy_out && quick_off_req_in && !emergency_req_in && powered_indicator_in
    |-> ##[1:3] !quick_off_pin_out) else $error("quick pin did not fall");
endmodule
bind mpk_host_ctrl mpk_host_sva u_sva (.*);

// File: mpk_dev_model.sv
/*
  Behavioural cellular module seen from its control pins.
  Assumes pins are already resolved with their pull-ups; counts are in clocks.
*/
module mpk_dev_model #(
  parameter int ON_CYC = 16, OFF_CYC = 12, EOFF_CYC = 8, DETACH_CYC = 10
) (
  input  wire logic clk_in,
  input  wire logic key_n_in,
  input  wire logic eoff_n_in,
  input  wire logic quick_n_in,
  input  wire logic psm_in,
  output logic      ind_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial ind_out = 1'b0;
  logic quick_q = 1'b0, psm_q = 1'b0, asleep = 1'b0;
  int   low = 0, elow = 0, det = 0;
  always @(posedge clk_in) begin
    quick_q <= quick_n_in;
    psm_q <= psm_in;
    low <= key_n_in ? 0 : low + 1;
    elow <= eoff_n_in ? 0 : elow + 1;
    if (det > 0) begin
      det <= det - 1;
      if (det == 1) ind_out <= 1'b0;
    end else if (asleep) begin
      if (key_n_in && low >= ON_CYC) begin
        asleep <= 1'b0;
        ind_out <= 1'b1;
      end
    end else if (!eoff_n_in) begin
    end else if (elow >= EOFF_CYC) ind_out <= 1'b0;
    else if (key_n_in && low >= ON_CYC && !ind_out) ind_out <= 1'b1;
    else if (key_n_in && low >= OFF_CYC && ind_out) det <= DETACH_CYC;
    else if (ind_out && quick_q && !quick_n_in) ind_out <= 1'b0;
    else if (ind_out && psm_in && !psm_q) begin
      ind_out <= 1'b0;
      asleep <= 1'b1;
    end
  end
endmodule

// File: tb.sv
/*
  Self-checking bench for the power-key host controller.
  Assumes shortened press counts (2 clocks per ms) and the behavioural module model.
*/
`include "mpk_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, rst_b_in = 0, supply = 0, psm = 0, usb = 1;
  logic [4:0] rq = 0;
  wire key_oe_b, key_o, eoff_oe_b, eoff_o, qpin, usb_en, busy, on, slp, done, ind;
  wire [1:0] err;
  wire key_n = key_oe_b ? 1'b1 : key_o;
  wire eoff_n = eoff_oe_b ? 1'b1 : eoff_o;
  int err_total = 0, checks_done = 0, k, e, c;
  always #25 clk_sys_in = ~clk_sys_in;
  // the tick and the presses are shortened; the off wait and the timeouts keep their full millisecond counts
  mpk_host_ctrl #(.TICKS_PER_MS(16'h2), .ON_PRESS_MS(16'h8), .OFF_PRESS_MS(16'h6), .WAKE_PRESS_MS(16'h8),
    .EOFF_PRESS_MS(16'h4)) u_dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .power_on_req_in(rq[0]), .wake_req_in(rq[1]),
    .power_off_req_in(rq[2]), .quick_off_req_in(rq[3]), .emergency_req_in(rq[4]),
    .main_supply_ok_in(supply), .powered_indicator_in(ind), .psm_active_in(psm), .usb_present_in(usb),
    .power_key_out(key_o), .power_key_oe_b_out(key_oe_b), .emergency_off_n_out(eoff_o),
    .emergency_off_n_oe_b_out(eoff_oe_b), .quick_off_pin_out(qpin), .usb_supply_sense_en_out(usb_en),
    .busy_out(busy), .module_on_out(on), .deep_sleep_out(slp), .done_out(done), .error_out(err));
  mpk_dev_model u_dev (.clk_in(clk_sys_in), .key_n_in(key_n), .eoff_n_in(eoff_n), .quick_n_in(qpin),
    .psm_in(psm), .ind_out(ind));
  task chk(input string n, input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task run(input logic [4:0] r);
    k = 0; e = 0; c = 0;
    @(negedge clk_sys_in) rq = r;
    @(negedge clk_sys_in) rq = 0;
    repeat (3000) begin
      k += !key_oe_b;
      e += !eoff_oe_b;
      if (done === 1'b1) break;
      c++;
      @(negedge clk_sys_in);
    end
    chk("done", done, 1);
    @(negedge clk_sys_in);
  endtask
  task t_on;
    supply = 0;
    @(negedge clk_sys_in) rq = 5'h1;
    @(negedge clk_sys_in) rq = 0;
    repeat (4) @(negedge clk_sys_in);
    chk("busy", busy, 0);
    supply = 1;
    run(5'h1);
    chk("on_press", k >= 16 && k <= 18, 1);
    chk("on_err", err, 0);
    chk("on_state", on, 1);
    chk("on_eoff", e, 0);
    chk("quick_pin", qpin, 1);
    chk("usb_on", usb_en, 1);
    usb = 0;
    repeat (2) @(negedge clk_sys_in);
    chk("usb_gone", usb_en, 0);
    usb = 1;
    repeat (2) @(negedge clk_sys_in);
    $display("t_on finished");
  endtask
  task t_off;
    run(5'h4);
    chk("off_press", k >= 12 && k <= 14, 1);
    chk("off_time", c >= 2 * `MPK_OFF_WAIT_MS, 1);
    chk("off_state", on, 0);
    chk("off_err", err, 0);
    $display("t_off finished");
  endtask
  task t_quick;
    run(5'h8);
    chk("quick_state", on, 0);
    chk("quick_press", k, 0);
    chk("quick_err", err, 0);
    $display("t_quick finished");
  endtask
  task t_eoff(input logic refuse);
    run(5'h10);
    chk("eoff_err", err, refuse ? 2'h3 : 2'h0);
    chk("eoff_press", refuse ? e == 0 : e >= 8 && e <= 10, 1);
    chk("eoff_state", on, 0);
    chk("eoff_key", k, 0);
    $display("t_eoff finished");
  endtask
  task t_psm;
    psm = 1;
    repeat (4) @(negedge clk_sys_in);
    chk("usb_en", usb_en, 0);
    chk("sleep", slp, 1);
    run(5'h10);
    chk("psm_eoff", err, 2'h3);
    run(5'h2);
    chk("wake_press", k >= 16 && k <= 18, 1);
    chk("wake_state", ind, 1);
    psm = 0;
    $display("t_psm finished");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    end_sim;
  end
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_b_in = 1;
    t_on;
    t_off;
    t_eoff(1'b1);
    t_on;
    t_quick;
    t_on;
    t_eoff(1'b0);
    t_on;
    t_psm;
    end_sim;
  end
endmodule
